//--- verilog/imgaoi_defines.svh
// Register offsets, field positions, reset values and limits of the image geometry block.
`ifndef IMGAOI_DEFINES_SVH
`define IMGAOI_DEFINES_SVH
`define IMGAOI_ADR_SENSOR_COLS 8'h00
`define IMGAOI_ADR_SENSOR_ROWS 8'h04
`define IMGAOI_ADR_WIDTH 8'h08
`define IMGAOI_ADR_HEIGHT 8'h0c
`define IMGAOI_ADR_MAX_COLS 8'h10
`define IMGAOI_ADR_MAX_ROWS 8'h14
`define IMGAOI_ADR_START_COL 8'h18
`define IMGAOI_ADR_START_ROW 8'h1c
`define IMGAOI_ADR_TAPS 8'h20
`define IMGAOI_ADR_DEPTH 8'h24
`define IMGAOI_ADR_CENTRAL 8'h28
`define IMGAOI_ADR_MAN_GAIN 8'h2c
`define IMGAOI_ADR_AUTO_SEL 8'h30
`define IMGAOI_ADR_AUTO_GAIN 8'h34
`define IMGAOI_ADR_OFFSET_LVL 8'h38
`define IMGAOI_ADR_SAVE_TGT 8'h3c
`define IMGAOI_ADR_SAVE_CMD 8'h40
`define IMGAOI_ADR_STATUS 8'h44
`define IMGAOI_SENSOR_COLS 11'h65c
`define IMGAOI_SENSOR_ROWS 11'h4d4
`define IMGAOI_MAX_COLS 11'h65c
`define IMGAOI_MAX_ROWS 11'h402
`define IMGAOI_MIN_SIZE 11'h002
`define IMGAOI_TAPS 8'h01
`define IMGAOI_RST_GAIN 8'h00
`define IMGAOI_RST_LEVEL 8'h00
`define IMGAOI_ST_SAVED_BIT 0
`define IMGAOI_ST_REFUSED_BIT 1
`define IMGAOI_ST_REJECT_BIT 2
`endif

//--- verilog/imgaoi_pkg.sv
// Types shared by the image geometry configuration block.
package imgaoi_pkg;
   typedef enum logic [1:0] {
      IMGAOI_DEPTH8 = 2'h0,
      IMGAOI_DEPTH10 = 2'h1,
      IMGAOI_DEPTH12 = 2'h2
   } imgaoi_depth_t;
   typedef enum logic {IMGAOI_TGT_DEFAULT = 1'h0, IMGAOI_TGT_USER1 = 1'h1} imgaoi_target_t;
   typedef struct packed {
      logic [10:0] width;
      logic [10:0] height;
      logic [10:0] startCol;
      logic [10:0] startRow;
      imgaoi_depth_t depth;
      logic central;
      logic [7:0] manualGain;
      logic autoGainSel;
      logic [7:0] autoGain;
      logic [7:0] offsetLevel;
   } imgaoi_settings_t;
endpackage : imgaoi_pkg

//--- verilog/imgaoi_range_check.sv
// Window range checker: tells whether a proposed geometry value may be accepted.
`timescale 1ns/1ns
`default_nettype none
`include "imgaoi_defines.svh"
module imgaoi_range_check
   import imgaoi_pkg::*;
#(
   parameter logic [10:0] LIMIT = 11'h65c
) (
   // Proposed value and the other setting that shares the axis: the start for a size, the size for a start.
   input wire logic [10:0] value,
   input wire logic [10:0] other,
   input wire logic isSize,
   // Verdict.
   output logic ok
);
   // A size sits in [2, limit-start]; a start sits in [0, limit-size]; both stay even.
   always_comb begin
      if (value[0]) begin
         ok = 1'b0;
      end else if (isSize) begin
         ok = (value >= `IMGAOI_MIN_SIZE) && ({1'b0, value} + {1'b0, other} <= {1'b0, LIMIT});
      end else begin
         ok = ({1'b0, value} + {1'b0, other} <= {1'b0, LIMIT});
      end
   end
endmodule : imgaoi_range_check
`default_nettype wire

//--- verilog/imgaoi_user_set.sv
// Stored copy of the user settings set, written by a save command.
`timescale 1ns/1ns
`default_nettype none
module imgaoi_user_set
   import imgaoi_pkg::*;
(
   // Clock and reset.
   input wire logic sysClk,
   input wire logic rstSync_n,
   // Save request.
   input wire logic store,
   input var imgaoi_settings_t current,
   // Stored content.
   output imgaoi_settings_t stored,
   output logic valid
);
   always_ff @(posedge sysClk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         stored <= '0;
         valid <= 1'b0;
      end else if (store) begin
         stored <= current;
         valid <= 1'b1;
      end
   end
endmodule : imgaoi_user_set
`default_nettype wire

//--- verilog/imgaoi_config.sv
// Image geometry and level configuration registers behind a classic Wishbone slave.
//
// The register addresses and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "imgaoi_defines.svh"
// Summary of operation
// - Sensor width reads back as a fixed 1628 pixels.
// - Sensor height reads back as a fixed 1236 pixels.
// - Image width is read/write, from 2 up to the maximum width.
// - Image height is read/write, at least 2 pixels.
// - Maximum width reads 1628 and bounds width and horizontal start.
// - Maximum height reads back as a fixed 1026 pixels.
// - Horizontal start runs 0 to maximum width minus width, even steps.
// - Vertical start runs from 0 in even steps, window inside maximum area.
// - One output tap, reported read-only.
// - Bit depth selects 8, 10 or 12 bit words; pixels follow it.
// - Central readout off gives full scan, on gives central area only.
// - Manual gain mode applies an 8-bit writable gain value.
// - Auto gain select turns automatic gain off or continuously on.
// - Automatic gain mode uses its own 8-bit writable gain value.
// - A writable 8-bit offset level is added to the image.
// - Save target selects factory default or first user set.
// - A save command stores all current settings into the target set, which must be the first user set.
// - Saving into the factory default set is refused.
module imgaoi_config
   import imgaoi_pkg::*;
(
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst_n,
   // Wishbone slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   // Settings applied to the imaging path.
   output imgaoi_settings_t active,
   output logic [7:0] appliedGain,
   output logic [3:0] pixelBits,
   output logic [10:0] readWidth,
   output logic [10:0] readStartCol,
   output logic [10:0] readStartRow,
   output logic userSetValid
);
   logic rstMeta_n;
   logic rstSync_n;
   imgaoi_settings_t cfg;
   imgaoi_settings_t storedSet;
   logic storedValid;
   logic saveStrobe;
   imgaoi_target_t saveTarget;
   logic saveDone;
   logic saveRefused;
   logic writeRejected;
   logic okWidth, okHeight, okCol, okRow;
   logic request;
   logic writeNow;
   logic highBitsClear;
   logic mapped;
   logic [31:0] next_rdata;
   logic [10:0] wVal;
   logic [1:0] next_depthCode;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_n <= 1'b0;
         rstSync_n <= 1'b0;
      end else begin
         rstMeta_n <= 1'b1;
         rstSync_n <= rstMeta_n;
      end
   end

   // A request is answered one cycle after it appears; ack drops the cycle after.
   assign request = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   assign writeNow = request && wb_we_i && mapped && wb_sel_i[0];
   assign wVal = wb_dat_i[10:0];

   always_comb begin
      mapped = 1'b1;
      next_rdata = 32'h0000_0000;
      case (wb_adr_i)
         `IMGAOI_ADR_SENSOR_COLS: next_rdata = {21'h0, `IMGAOI_SENSOR_COLS};
         `IMGAOI_ADR_SENSOR_ROWS: next_rdata = {21'h0, `IMGAOI_SENSOR_ROWS};
         `IMGAOI_ADR_WIDTH: next_rdata = {21'h0, cfg.width};
         `IMGAOI_ADR_HEIGHT: next_rdata = {21'h0, cfg.height};
         `IMGAOI_ADR_MAX_COLS: next_rdata = {21'h0, `IMGAOI_MAX_COLS};
         `IMGAOI_ADR_MAX_ROWS: next_rdata = {21'h0, `IMGAOI_MAX_ROWS};
         `IMGAOI_ADR_START_COL: next_rdata = {21'h0, cfg.startCol};
         `IMGAOI_ADR_START_ROW: next_rdata = {21'h0, cfg.startRow};
         `IMGAOI_ADR_TAPS: next_rdata = {24'h0, `IMGAOI_TAPS};
         `IMGAOI_ADR_DEPTH: next_rdata = {30'h0, cfg.depth};
         `IMGAOI_ADR_CENTRAL: next_rdata = {31'h0, cfg.central};
         `IMGAOI_ADR_MAN_GAIN: next_rdata = {24'h0, cfg.manualGain};
         `IMGAOI_ADR_AUTO_SEL: next_rdata = {31'h0, cfg.autoGainSel};
         `IMGAOI_ADR_AUTO_GAIN: next_rdata = {24'h0, cfg.autoGain};
         `IMGAOI_ADR_OFFSET_LVL: next_rdata = {24'h0, cfg.offsetLevel};
         `IMGAOI_ADR_SAVE_TGT: next_rdata = {31'h0, saveTarget};
         `IMGAOI_ADR_SAVE_CMD: next_rdata = 32'h0000_0000;
         `IMGAOI_ADR_STATUS: next_rdata = {28'h0, storedValid, writeRejected, saveRefused,
                                           saveDone};
         default: mapped = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= request && mapped;
         wb_err_o <= request && !mapped;
         wb_dat_o <= (request && mapped && !wb_we_i) ? next_rdata : 32'h0000_0000;
      end
   end

   imgaoi_range_check #(.LIMIT(`IMGAOI_MAX_COLS)) uChkWidth (
      .value(wVal), .other(cfg.startCol), .isSize(1'b1), .ok(okWidth));
   imgaoi_range_check #(.LIMIT(`IMGAOI_MAX_ROWS)) uChkHeight (
      .value(wVal), .other(cfg.startRow), .isSize(1'b1), .ok(okHeight));
   imgaoi_range_check #(.LIMIT(`IMGAOI_MAX_COLS)) uChkCol (
      .value(wVal), .other(cfg.width), .isSize(1'b0), .ok(okCol));
   imgaoi_range_check #(.LIMIT(`IMGAOI_MAX_ROWS)) uChkRow (
      .value(wVal), .other(cfg.height), .isSize(1'b0), .ok(okRow));

   // Upper data bits are checked too, so a huge value cannot alias into range.
   assign highBitsClear = wb_dat_i[31:11] == 21'h0;

   always_comb begin
      next_depthCode = wb_dat_i[1:0];
   end

   // One process owns the whole settings struct, so no member has two drivers.
   always_ff @(posedge sys_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         cfg.width <= `IMGAOI_MAX_COLS;
         cfg.height <= `IMGAOI_MAX_ROWS;
         cfg.startCol <= 11'h000;
         cfg.startRow <= 11'h000;
         cfg.depth <= IMGAOI_DEPTH12;
         cfg.central <= 1'b0;
         cfg.manualGain <= `IMGAOI_RST_GAIN;
         cfg.autoGainSel <= 1'b0;
         cfg.autoGain <= `IMGAOI_RST_GAIN;
         cfg.offsetLevel <= `IMGAOI_RST_LEVEL;
         saveTarget <= IMGAOI_TGT_USER1;
      end else if (writeNow) begin
         case (wb_adr_i)
            `IMGAOI_ADR_WIDTH: if (okWidth && highBitsClear) cfg.width <= wVal;
            `IMGAOI_ADR_HEIGHT: if (okHeight && highBitsClear) cfg.height <= wVal;
            `IMGAOI_ADR_START_COL: if (okCol && highBitsClear) cfg.startCol <= wVal;
            `IMGAOI_ADR_START_ROW: if (okRow && highBitsClear) cfg.startRow <= wVal;
            `IMGAOI_ADR_DEPTH: begin
               if (next_depthCode != 2'h3) begin
                  cfg.depth <= imgaoi_depth_t'(next_depthCode);
               end
            end
            `IMGAOI_ADR_CENTRAL: cfg.central <= wb_dat_i[0];
            `IMGAOI_ADR_MAN_GAIN: cfg.manualGain <= wb_dat_i[7:0];
            `IMGAOI_ADR_AUTO_SEL: cfg.autoGainSel <= wb_dat_i[0];
            `IMGAOI_ADR_AUTO_GAIN: cfg.autoGain <= wb_dat_i[7:0];
            `IMGAOI_ADR_OFFSET_LVL: cfg.offsetLevel <= wb_dat_i[7:0];
            `IMGAOI_ADR_SAVE_TGT: saveTarget <= imgaoi_target_t'(wb_dat_i[0]);
            default: ;
         endcase
      end
   end

   // Status flags: set on the event, cleared by writing one; a new event wins the clear.
   assign saveStrobe = writeNow && wb_adr_i == `IMGAOI_ADR_SAVE_CMD && wb_dat_i[0]
                       && saveTarget == IMGAOI_TGT_USER1;
   always_ff @(posedge sys_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         saveDone <= 1'b0;
         saveRefused <= 1'b0;
         writeRejected <= 1'b0;
      end else begin
         if (writeNow && wb_adr_i == `IMGAOI_ADR_STATUS) begin
            saveDone <= saveDone & ~wb_dat_i[`IMGAOI_ST_SAVED_BIT];
            saveRefused <= saveRefused & ~wb_dat_i[`IMGAOI_ST_REFUSED_BIT];
            writeRejected <= writeRejected & ~wb_dat_i[`IMGAOI_ST_REJECT_BIT];
         end
         if (saveStrobe) begin
            saveDone <= 1'b1;
         end
         if (writeNow && wb_adr_i == `IMGAOI_ADR_SAVE_CMD && wb_dat_i[0]
             && saveTarget == IMGAOI_TGT_DEFAULT) begin
            saveRefused <= 1'b1;
         end
         if (writeNow && ((wb_adr_i == `IMGAOI_ADR_WIDTH && !(okWidth && highBitsClear))
             || (wb_adr_i == `IMGAOI_ADR_HEIGHT && !(okHeight && highBitsClear))
             || (wb_adr_i == `IMGAOI_ADR_START_COL && !(okCol && highBitsClear))
             || (wb_adr_i == `IMGAOI_ADR_START_ROW && !(okRow && highBitsClear)))) begin
            writeRejected <= 1'b1;
         end
      end
   end

   imgaoi_user_set uUserSet (
      .sysClk(sys_clk),
      .rstSync_n(rstSync_n),
      .store(saveStrobe),
      .current(cfg),
      .stored(storedSet),
      .valid(storedValid)
   );

   // Applied values are registered so the imaging path never sees a half-written set.
   always_ff @(posedge sys_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         active <= '0;
         appliedGain <= 8'h00;
         pixelBits <= 4'hc;
         readWidth <= `IMGAOI_MAX_COLS;
         readStartCol <= 11'h000;
         readStartRow <= 11'h000;
         userSetValid <= 1'b0;
      end else begin
         active <= cfg;
         appliedGain <= cfg.autoGainSel ? cfg.autoGain : cfg.manualGain;
         case (cfg.depth)
            IMGAOI_DEPTH8: pixelBits <= 4'h8;
            IMGAOI_DEPTH10: pixelBits <= 4'ha;
            default: pixelBits <= 4'hc;
         endcase
         // Central readout centres the window in the maximum area, on an even start, ignoring the start offsets.
         readWidth <= cfg.width;
         readStartCol <= cfg.central ?
            (11'(`IMGAOI_MAX_COLS - cfg.width) >> 1) & 11'h7fe : cfg.startCol;
         readStartRow <= cfg.central ?
            (11'(`IMGAOI_MAX_ROWS - cfg.height) >> 1) & 11'h7fe : cfg.startRow;
         userSetValid <= storedValid;
      end
   end

   chk_ack_one_cycle: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
      wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");
   chk_width_range: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
      cfg.width >= 11'h002 && cfg.width + cfg.startCol <= 11'h65c && !cfg.width[0])
      else $error("width outside its range");
   chk_height_range: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
      cfg.height >= 11'h002 && !cfg.height[0]) else $error("height below minimum");
   chk_col_window: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
      !cfg.startCol[0]) else $error("column start odd");
   chk_row_window: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
      cfg.startRow + cfg.height <= 11'h402 && !cfg.startRow[0])
      else $error("row window outside area");
   chk_gain_pick: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
      1'b1 |=> appliedGain == ($past(cfg.autoGainSel) ? $past(cfg.autoGain)
                                                      : $past(cfg.manualGain)))
      else $error("applied gain from wrong source");
   chk_save_stores: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
      saveStrobe |=> storedSet == $past(cfg) && storedValid)
      else $error("save did not store settings");
   chk_default_refused: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
      writeNow && wb_adr_i == `IMGAOI_ADR_SAVE_CMD && wb_dat_i[0]
      && saveTarget == IMGAOI_TGT_DEFAULT |=> saveRefused && $stable(storedSet))
      else $error("save into default set");
   chk_depth_bits: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
      cfg.depth == IMGAOI_DEPTH8 [*2] |-> pixelBits == 4'h8)
      else $error("pixel depth mismatch");
   chk_fixed_reads: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
      request && !wb_we_i && wb_adr_i == `IMGAOI_ADR_SENSOR_COLS |=> wb_dat_o == 32'h65c)
      else $error("sensor width read wrong");
   // Read-only values must come back whatever was last written to them.
   chk_rows_read: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
      request && !wb_we_i && wb_adr_i == `IMGAOI_ADR_SENSOR_ROWS |=> wb_dat_o == 32'h4d4)
      else $error("sensor height read wrong");
   chk_max_cols_read: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
      request && !wb_we_i && wb_adr_i == `IMGAOI_ADR_MAX_COLS |=> wb_dat_o == 32'h65c)
      else $error("maximum width read wrong");
   chk_max_rows_read: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
      request && !wb_we_i && wb_adr_i == `IMGAOI_ADR_MAX_ROWS |=> wb_dat_o == 32'h402)
      else $error("maximum height read wrong");
   chk_taps_read: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
      request && !wb_we_i && wb_adr_i == `IMGAOI_ADR_TAPS |=> wb_dat_o == 32'h1)
      else $error("tap count read wrong");
   chk_full_scan: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
      !cfg.central |=> readStartCol == $past(cfg.startCol) && readStartRow == $past(cfg.startRow))
      else $error("full scan start not applied");
   chk_odd_kept: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
      writeNow && wb_adr_i == `IMGAOI_ADR_WIDTH && wb_dat_i[0] |=> $stable(cfg.width))
      else $error("odd width accepted");
   chk_manual_write: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
      writeNow && wb_adr_i == `IMGAOI_ADR_MAN_GAIN |=> cfg.manualGain == $past(wb_dat_i[7:0]))
      else $error("manual gain not stored");
   chk_auto_write: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
      writeNow && wb_adr_i == `IMGAOI_ADR_AUTO_GAIN |=> cfg.autoGain == $past(wb_dat_i[7:0]))
      else $error("auto gain not stored");
   chk_level_write: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
      writeNow && wb_adr_i == `IMGAOI_ADR_OFFSET_LVL |=> cfg.offsetLevel == $past(wb_dat_i[7:0]))
      else $error("offset level not stored");
   chk_target_write: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
      writeNow && wb_adr_i == `IMGAOI_ADR_SAVE_TGT |=> saveTarget == $past(wb_dat_i[0]))
      else $error("save target not stored");
   cov_save: cover property (@(posedge sys_clk) disable iff (!rstSync_n) saveStrobe);
   cov_refused: cover property (@(posedge sys_clk) disable iff (!rstSync_n) $rose(saveRefused));
   cov_reject: cover property (@(posedge sys_clk) disable iff (!rstSync_n) $rose(writeRejected));
   cov_central: cover property (@(posedge sys_clk) disable iff (!rstSync_n) cfg.central);
   cov_depth8: cover property (@(posedge sys_clk) disable iff (!rstSync_n)
      cfg.depth == IMGAOI_DEPTH8);
endmodule : imgaoi_config
`default_nettype wire

//--- dv/tb.sv
// Self-checking testbench for the image geometry configuration block.
`timescale 1ns/1ns
`default_nettype none
`include "imgaoi_defines.svh"
module tb
   import imgaoi_pkg::*;
;
   logic sysClk;
   logic sysRst_n;
   logic wb_cyc;
   logic wb_stb;
   logic wb_we;
   logic [7:0] wb_adr;
   logic [3:0] wb_sel;
   logic [31:0] wb_dat_w;
   logic [31:0] wb_dat_r;
   logic wb_ack;
   logic wb_err;
   imgaoi_settings_t active;
   logic [7:0] appliedGain;
   logic [3:0] pixelBits;
   logic [10:0] readWidth;
   logic [10:0] readStartCol;
   logic [10:0] readStartRow;
   logic userSetValid;
   logic [31:0] rdData;
   logic lastErr;
   int err_total;
   int n_compared;

   imgaoi_config i_dut (
      .sys_clk(sysClk),
      .rst_n(sysRst_n),
      .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb),
      .wb_we_i(wb_we),
      .wb_adr_i(wb_adr),
      .wb_sel_i(wb_sel),
      .wb_dat_i(wb_dat_w),
      .wb_dat_o(wb_dat_r),
      .wb_ack_o(wb_ack),
      .wb_err_o(wb_err),
      .active(active),
      .appliedGain(appliedGain),
      .pixelBits(pixelBits),
      .readWidth(readWidth),
      .readStartCol(readStartCol),
      .readStartRow(readStartRow),
      .userSetValid(userSetValid)
   );

   always #10 sysClk = ~sysClk;

   task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   // One classic cycle; the answer edge is waited for, never assumed.
   task bus(input logic we, input logic [7:0] adr, input logic [31:0] dat,
            input logic [3:0] sel);
      int waitCount;
      @(posedge sysClk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_dat_w <= dat;
      wb_sel <= sel;
      waitCount = 0;
      do begin
         @(posedge sysClk);
         waitCount++;
      end while (!(wb_ack === 1'b1 || wb_err === 1'b1) && waitCount < 50);
      if (waitCount >= 50) begin
         check(32'h0, 32'h1, "no bus answer");
      end
      rdData = wb_dat_r;
      lastErr = wb_err;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
   endtask : bus

   task wr(input logic [7:0] adr, input logic [31:0] dat);
      bus(1'b1, adr, dat, 4'hf);
   endtask : wr

   task rdchk(input logic [7:0] adr, input logic [31:0] exp, input string what);
      bus(1'b0, adr, 32'h0, 4'hf);
      check(rdData, exp, what);
   endtask : rdchk

   // Outputs are registered a cycle or two behind the register write.
   task settle;
      repeat (3) @(posedge sysClk);
   endtask : settle

   task results;
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : results

   initial begin
      repeat (5000) @(posedge sysClk);
      check(32'h0, 32'h1, "watchdog expired");
      results();
   end

   initial begin
      sysClk = 1'b0;
      sysRst_n = 1'b0;
      wb_cyc = 1'b0;
      wb_stb = 1'b0;
      wb_we = 1'b0;
      wb_adr = 8'h00;
      wb_sel = 4'h0;
      wb_dat_w = 32'h0;
      err_total = 0;
      n_compared = 0;
      repeat (20) @(posedge sysClk);
      sysRst_n <= 1'b1;
      repeat (3) @(posedge sysClk);
      rdchk(`IMGAOI_ADR_SENSOR_COLS, 32'h65c, "sensor columns");
      rdchk(`IMGAOI_ADR_SENSOR_ROWS, 32'h4d4, "sensor rows");
      wr(`IMGAOI_ADR_MAX_COLS, 32'h100);
      rdchk(`IMGAOI_ADR_MAX_COLS, 32'h65c, "max columns");
      rdchk(`IMGAOI_ADR_MAX_ROWS, 32'h402, "max rows");
      rdchk(`IMGAOI_ADR_TAPS, 32'h1, "tap count");
      wr(8'h80, 32'h1);
      check(lastErr, 1'b1, "unmapped address error");
      $display("test fixed values done");
      wr(`IMGAOI_ADR_WIDTH, 32'h3e8);
      rdchk(`IMGAOI_ADR_WIDTH, 32'h3e8, "width 1000");
      wr(`IMGAOI_ADR_START_COL, 32'h274);
      rdchk(`IMGAOI_ADR_START_COL, 32'h274, "start column 628");
      wr(`IMGAOI_ADR_STATUS, 32'h7);
      wr(`IMGAOI_ADR_START_COL, 32'h276);
      rdchk(`IMGAOI_ADR_START_COL, 32'h274, "start past edge kept");
      rdchk(`IMGAOI_ADR_STATUS, 32'h4, "reject flag");
      wr(`IMGAOI_ADR_START_COL, 32'h3);
      rdchk(`IMGAOI_ADR_START_COL, 32'h274, "odd start kept");
      wr(`IMGAOI_ADR_WIDTH, 32'h1);
      rdchk(`IMGAOI_ADR_WIDTH, 32'h3e8, "width below 2 kept");
      wr(`IMGAOI_ADR_WIDTH, 32'h3ea);
      rdchk(`IMGAOI_ADR_WIDTH, 32'h3e8, "width past edge kept");
      wr(`IMGAOI_ADR_HEIGHT, 32'h802);
      rdchk(`IMGAOI_ADR_HEIGHT, 32'h402, "aliased height kept");
      wr(`IMGAOI_ADR_HEIGHT, 32'h2);
      rdchk(`IMGAOI_ADR_HEIGHT, 32'h2, "height 2");
      wr(`IMGAOI_ADR_START_ROW, 32'h400);
      rdchk(`IMGAOI_ADR_START_ROW, 32'h400, "start row 1024");
      wr(`IMGAOI_ADR_START_ROW, 32'h402);
      rdchk(`IMGAOI_ADR_START_ROW, 32'h400, "start row past edge kept");
      settle();
      check(readWidth, 11'h3e8, "read width");
      check(readStartCol, 11'h274, "read start column");
      $display("test window done");
      wr(`IMGAOI_ADR_CENTRAL, 32'h1);
      settle();
      check(readStartCol, 11'h13a, "centred start column");
      check(readStartRow, 11'h200, "centred start row");
      wr(`IMGAOI_ADR_CENTRAL, 32'h0);
      settle();
      check(readStartCol, 11'h274, "full scan start column");
      $display("test central readout done");
      for (int i = 0; i < 3; i++) begin
         wr(`IMGAOI_ADR_DEPTH, i);
         settle();
         check(pixelBits, 8 + 2 * i, "pixel depth");
      end
      wr(`IMGAOI_ADR_DEPTH, 32'h3);
      rdchk(`IMGAOI_ADR_DEPTH, 32'h2, "bad depth code kept");
      $display("test depth done");
      wr(`IMGAOI_ADR_MAN_GAIN, 32'ha5);
      wr(`IMGAOI_ADR_AUTO_GAIN, 32'h3c);
      bus(1'b1, `IMGAOI_ADR_MAN_GAIN, 32'h11, 4'he);
      rdchk(`IMGAOI_ADR_MAN_GAIN, 32'ha5, "lane-less write ignored");
      rdchk(`IMGAOI_ADR_AUTO_GAIN, 32'h3c, "auto gain value");
      for (int i = 0; i < 2; i++) begin
         wr(`IMGAOI_ADR_AUTO_SEL, i);
         settle();
         check(appliedGain, (i == 1) ? 8'h3c : 8'ha5, "applied gain");
      end
      wr(`IMGAOI_ADR_OFFSET_LVL, 32'hff);
      settle();
      check(active.offsetLevel, 8'hff, "offset level");
      $display("test gain and level done");
      wr(`IMGAOI_ADR_STATUS, 32'h7);
      wr(`IMGAOI_ADR_SAVE_TGT, 32'h0);
      wr(`IMGAOI_ADR_SAVE_CMD, 32'h1);
      rdchk(`IMGAOI_ADR_STATUS, 32'h2, "default save refused");
      check(userSetValid, 1'b0, "no user set yet");
      wr(`IMGAOI_ADR_STATUS, 32'h7);
      wr(`IMGAOI_ADR_SAVE_TGT, 32'h1);
      rdchk(`IMGAOI_ADR_SAVE_TGT, 32'h1, "save target");
      wr(`IMGAOI_ADR_SAVE_CMD, 32'h1);
      rdchk(`IMGAOI_ADR_STATUS, 32'h9, "user save done");
      settle();
      check(userSetValid, 1'b1, "user set valid");
      $display("test save done");
      results();
   end
endmodule : tb
`default_nettype wire
